// ==== src/fci_cpu.sv ====
`timescale 1ns/1ps
`default_nettype none
module fci_cpu (
    input wire logic clock,
    input wire logic rst_n,
    fci_if.cpu bus,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic req_from_flash,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic code_unprotected
);
    // Each request becomes one bus cycle, but a read requested with a write is dropped; write routines that touch
    // protected code must first issue the unprotect write from flash.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.addr <= 20'h00000;
            bus.wdata <= 16'h0000;
            bus.fetch_from_flash <= 1'b0;
        end else begin
            bus.wr <= req_wr;
            bus.rd <= req_rd && !req_wr;
            if (req_wr || req_rd) begin
                bus.addr <= req_addr;
                bus.wdata <= req_wdata;
                bus.fetch_from_flash <= req_from_flash;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= bus.rd;
            rd_data <= bus.rdata;
        end
    end

    assign busy = bus.busy;
    assign code_unprotected = bus.code_unprotected;
endmodule
`default_nettype wire

// ==== src/fci_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module fci_device #(
    parameter int ERASE_TIMEOUT = fci_pkg::ERASE_TIMEOUT_CYC,
    parameter logic [15:0] PROG_CYC = fci_pkg::PROG_CYC_DEF,
    parameter logic [15:0] ERASE_CYC = fci_pkg::ERASE_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    fci_if.device bus,
    input wire logic [15:0] array_rdata,
    output logic prog_req,
    output logic [19:0] prog_addr,
    output logic [15:0] prog_data,
    output logic [19:0] erase_block_addr,
    output logic erase_block_req,
    output logic chip_erase_req,
    output logic erase_suspended
);
    typedef enum logic [3:0] {
        FCI_READ, FCI_U1, FCI_U2, FCI_PROG_DATA, FCI_E3, FCI_E4, FCI_E5,
        FCI_TIMEOUT, FCI_PROGRAMMING, FCI_ERASING, FCI_SUSPENDED
    } fci_state_t;

    fci_state_t state_q;
    logic [31:0] timer_q;
    logic toggle_q;
    logic unprot_q;
    logic [7:0] cmd;
    logic [15:0] status;
    logic is_a, is_b;

    assign cmd = bus.wdata[7:0];
    assign is_a = fci_pkg::is_code(bus.addr, fci_pkg::ADDR_1554);
    assign is_b = fci_pkg::is_code(bus.addr, fci_pkg::ADDR_2AA8);

    // Sequencer; an unexpected write in an unlock or timeout step falls back to array read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FCI_READ;
        end else if (bus.wr && !bus.fetch_from_flash) begin
            unique case (state_q)
                FCI_READ, FCI_U1: begin
                    if (cmd == fci_pkg::CMD_UNLOCK1 && is_a) begin
                        state_q <= FCI_U1;
                    end else begin
                        state_q <= FCI_READ;
                    end
                end
                default: state_q <= state_q;
            endcase
            if (state_q == FCI_U1) begin
                state_q <= (cmd == fci_pkg::CMD_UNLOCK2 && is_b) ? FCI_U2 : FCI_READ;
            end
            if (state_q == FCI_U2) begin
                if (cmd == fci_pkg::CMD_PROGRAM && is_a) begin
                    state_q <= FCI_PROG_DATA;
                end else if (cmd == fci_pkg::CMD_ERASE_EN && is_a) begin
                    state_q <= FCI_E3;
                end else begin
                    state_q <= FCI_READ;
                end
            end
            if (state_q == FCI_PROG_DATA) begin
                state_q <= FCI_PROGRAMMING;
            end
            if (state_q == FCI_E3) begin
                state_q <= (cmd == fci_pkg::CMD_UNLOCK1 && is_a) ? FCI_E4 : FCI_READ;
            end
            if (state_q == FCI_E4) begin
                state_q <= (cmd == fci_pkg::CMD_UNLOCK2 && is_b) ? FCI_E5 : FCI_READ;
            end
            if (state_q == FCI_E5) begin
                if (cmd == fci_pkg::CMD_BLOCK_CONFIRM) begin
                    state_q <= FCI_TIMEOUT;
                end else if (cmd == fci_pkg::CMD_CHIP_ERASE && is_a) begin
                    state_q <= FCI_ERASING;
                end else begin
                    state_q <= FCI_READ;
                end
            end
            if (state_q == FCI_TIMEOUT) begin
                if (cmd == fci_pkg::CMD_BLOCK_CONFIRM) begin
                    state_q <= FCI_TIMEOUT;
                end else if (cmd == fci_pkg::CMD_SUSPEND) begin
                    state_q <= FCI_SUSPENDED;
                end else begin
                    state_q <= FCI_READ;
                end
            end
            if (state_q == FCI_ERASING) begin
                if (cmd == fci_pkg::CMD_SUSPEND) begin
                    state_q <= FCI_SUSPENDED;
                end else if (cmd == fci_pkg::CMD_READ_RESET) begin
                    state_q <= FCI_READ;
                end else begin
                    state_q <= FCI_ERASING;
                end
            end
            if (state_q == FCI_SUSPENDED) begin
                // Resume with 30; reset here abandons the erase for good.
                if (cmd == fci_pkg::CMD_BLOCK_CONFIRM) begin
                    state_q <= FCI_ERASING;
                end else if (cmd == fci_pkg::CMD_READ_RESET) begin
                    state_q <= FCI_READ;
                end else begin
                    state_q <= FCI_SUSPENDED;
                end
            end
            if (state_q == FCI_PROGRAMMING) begin
                state_q <= FCI_PROGRAMMING;
            end
        end else if (state_q == FCI_TIMEOUT && timer_q == 32'h0000_0000) begin
            state_q <= FCI_ERASING;
        end else if (state_q == FCI_PROGRAMMING && timer_q == 32'h0000_0000) begin
            state_q <= FCI_READ;
        end else if (state_q == FCI_ERASING && timer_q == 32'h0000_0000) begin
            state_q <= FCI_READ;
        end
    end

    // One down counter serves timeout, program and erase durations.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= 32'h0000_0000;
        end else if (bus.wr && !bus.fetch_from_flash && cmd == fci_pkg::CMD_BLOCK_CONFIRM
                     && (state_q == FCI_E5 || state_q == FCI_TIMEOUT)) begin
            timer_q <= 32'(ERASE_TIMEOUT - 1);
        end else if (bus.wr && !bus.fetch_from_flash && state_q == FCI_PROG_DATA) begin
            timer_q <= 32'(PROG_CYC);
        end else if (state_q == FCI_TIMEOUT && timer_q == 32'h0000_0000) begin
            timer_q <= 32'(ERASE_CYC);
        end else if (bus.wr && !bus.fetch_from_flash && state_q == FCI_E5
                     && cmd == fci_pkg::CMD_CHIP_ERASE && is_a) begin
            timer_q <= 32'(ERASE_CYC);
        end else if (bus.wr && !bus.fetch_from_flash && state_q == FCI_TIMEOUT
                     && cmd == fci_pkg::CMD_SUSPEND) begin
            // Suspending inside the window ends it, so a resume erases in full.
            timer_q <= 32'(ERASE_CYC);
        end else if (timer_q != 32'h0000_0000 && state_q != FCI_SUSPENDED) begin
            timer_q <= timer_q - 32'h0000_0001;
        end
    end

    // Erase start and program pulses for the array engine.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_req <= 1'b0;
            prog_addr <= 20'h00000;
            prog_data <= 16'h0000;
            erase_block_req <= 1'b0;
            erase_block_addr <= 20'h00000;
            chip_erase_req <= 1'b0;
        end else begin
            prog_req <= bus.wr && !bus.fetch_from_flash && state_q == FCI_PROG_DATA;
            erase_block_req <= bus.wr && !bus.fetch_from_flash
                && cmd == fci_pkg::CMD_BLOCK_CONFIRM
                && (state_q == FCI_E5 || state_q == FCI_TIMEOUT);
            chip_erase_req <= bus.wr && !bus.fetch_from_flash && state_q == FCI_E5
                && cmd == fci_pkg::CMD_CHIP_ERASE && is_a;
            if (bus.wr && !bus.fetch_from_flash && state_q == FCI_PROG_DATA) begin
                prog_addr <= bus.addr;
                prog_data <= bus.wdata;
            end
            // Only a confirm accepted by the sequencer may move the block address.
            if (bus.wr && !bus.fetch_from_flash && cmd == fci_pkg::CMD_BLOCK_CONFIRM
                && (state_q == FCI_E5 || state_q == FCI_TIMEOUT)) begin
                erase_block_addr <= bus.addr;
            end
        end
    end

    // Flash-fetched writes carry only the code protection commands.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unprot_q <= 1'b0;
        end else if (bus.wr && bus.fetch_from_flash) begin
            if (bus.wdata == fci_pkg::DATA_TEMP_UNPROTECT) begin
                unprot_q <= 1'b1;
            end else if (bus.wdata == fci_pkg::DATA_TEMP_PROTECT) begin
                unprot_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q <= 1'b0;
        end else if (bus.rd && (state_q == FCI_PROGRAMMING || state_q == FCI_ERASING)) begin
            toggle_q <= !toggle_q;
        end
    end

    always_comb begin
        status = 16'h0000;
        status[fci_pkg::STATUS_POLL_BIT] = !(state_q == FCI_ERASING
            || state_q == FCI_PROGRAMMING || state_q == FCI_TIMEOUT);
        status[fci_pkg::STATUS_TOGGLE_BIT] = toggle_q;
        status[fci_pkg::STATUS_TOGGLE2_BIT] = toggle_q;
        status[fci_pkg::STATUS_TIMER_BIT] = state_q != FCI_TIMEOUT;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= 16'h0000;
        end else if (state_q == FCI_PROGRAMMING || state_q == FCI_ERASING
                     || state_q == FCI_TIMEOUT) begin
            bus.rdata <= status;
        end else begin
            bus.rdata <= array_rdata;
        end
    end

    assign bus.busy = state_q == FCI_PROGRAMMING || state_q == FCI_ERASING
        || state_q == FCI_TIMEOUT;
    assign bus.code_unprotected = unprot_q;
    assign erase_suspended = state_q == FCI_SUSPENDED;
endmodule
`default_nettype wire

// ==== src/fci_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fci_if;
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic fetch_from_flash;
    logic [15:0] rdata;
    logic busy;
    logic code_unprotected;

    modport device (
        input wr,
        input rd,
        input addr,
        input wdata,
        input fetch_from_flash,
        output rdata,
        output busy,
        output code_unprotected
    );
    modport cpu (
        output wr,
        output rd,
        output addr,
        output wdata,
        output fetch_from_flash,
        input rdata,
        input busy,
        input code_unprotected
    );
endinterface
`default_nettype wire

// ==== src/fci_pkg.sv ====
`default_nettype none
package fci_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CODE_ADDR_W = 14;
    localparam logic [13:0] ADDR_1554 = 14'h1554;
    localparam logic [13:0] ADDR_2AA8 = 14'h2AA8;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hA8;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h54;
    localparam logic [7:0] CMD_READ_RESET = 8'hF0;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_EN = 8'h80;
    localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [15:0] DATA_TEMP_UNPROTECT = 16'hFFFF;
    localparam logic [15:0] DATA_TEMP_PROTECT = 16'hFFFB;
    localparam int STATUS_POLL_BIT = 7;
    localparam int STATUS_TOGGLE_BIT = 6;
    localparam int STATUS_TIMER_BIT = 3;
    localparam int STATUS_TOGGLE2_BIT = 2;
    localparam int CLK_MHZ = 40;
    localparam int ERASE_TIMEOUT_US = 96;
    localparam int ERASE_TIMEOUT_CYC = ERASE_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W = 16;
    localparam logic [15:0] PROG_CYC_DEF = 16'h0010;
    localparam logic [15:0] ERASE_CYC_DEF = 16'h0100;

    function automatic logic is_code(input logic [19:0] a, input logic [13:0] c);
        return a[CODE_ADDR_W-1:0] == c;
    endfunction
endpackage
`default_nettype wire

// ==== verification/fci_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fci_checker_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    input wire logic fetch_from_flash,
    input wire logic [15:0] rdata,
    input wire logic busy,
    input wire logic code_unprotected
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic unp_w;
    logic pro_w;
    logic [9:0] bcnt_q;
    logic pend_data_q;
    assign unp_w = wr && fetch_from_flash && wdata == fci_pkg::DATA_TEMP_UNPROTECT;
    assign pro_w = wr && fetch_from_flash && wdata == fci_pkg::DATA_TEMP_PROTECT;
    // A data word that follows A0 may carry F0 in its low byte and still start programming.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_data_q <= 1'b0;
        end else if (wr && !fetch_from_flash) begin
            pend_data_q <= wdata[7:0] == fci_pkg::CMD_PROGRAM
                && addr[13:0] == fci_pkg::ADDR_1554;
        end
    end
    // Saturating run length of busy; a stuck sequencer shows up here.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_q <= 10'h000;
        end else if (!busy) begin
            bcnt_q <= 10'h000;
        end else if (bcnt_q != 10'h3FF) begin
            bcnt_q <= bcnt_q + 10'h001;
        end
    end
    a_unprot_sets: assert property (unp_w |=> code_unprotected)
        else $error("unprotect write ignored");
    a_unprot_cause: assert property ($rose(code_unprotected) |-> $past(unp_w))
        else $error("unprotect without flash write");
    a_protect_clears: assert property (pro_w |=> !code_unprotected)
        else $error("protect write ignored");
    a_protect_cause: assert property ($fell(code_unprotected) |-> $past(pro_w))
        else $error("protect without flash write");
    a_prot_holds: assert property (!unp_w && !pro_w |=> $stable(code_unprotected))
        else $error("protection changed by other write");
    a_poll_low: assert property (rd && busy |=> !rdata[7])
        else $error("poll bit high while busy");
    a_reset_idle: assert property (wr && !fetch_from_flash && wdata[7:0] == 8'hF0 && !busy
        && !pend_data_q |=> !busy [*2])
        else $error("busy after read reset");
    a_busy_min: assert property ($fell(busy) && !$past(wr) |-> $past(bcnt_q) > 10'h003)
        else $error("busy pulse too short");
    a_busy_bounded: assert property (bcnt_q < 10'h190)
        else $error("busy too long");
    c_unprot: cover property (unp_w);
    c_busy: cover property ($rose(busy));
    c_poll: cover property (rd && busy);
    c_coded: cover property (wr && addr[13:0] == 14'h1554);
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req_wr = 1'b0, req_rd = 1'b0, req_from_flash = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] array_rdata = 16'h0000;
    logic [15:0] rd_data, prog_data, got_d, rv, rv2, wa_d;
    logic [19:0] prog_addr, erase_block_addr, got_a, wa, ba;
    logic rd_valid, busy, code_unprotected, prog_req, erase_block_req, chip_erase_req;
    logic erase_suspended;
    int fails = 0, num_checks = 0, cycles = 0, nprog = 0, nblk = 0, nchip = 0, n;
    fci_if bus ();
    fci_device #(.ERASE_TIMEOUT(20), .ERASE_CYC(16'h0040)) u_fci_device (
        .clock(clock), .rst_n(rst_n), .bus(bus.device), .array_rdata(array_rdata),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
        .erase_block_addr(erase_block_addr), .erase_block_req(erase_block_req),
        .chip_erase_req(chip_erase_req), .erase_suspended(erase_suspended));
    fci_cpu u_fci_cpu (
        .clock(clock), .rst_n(rst_n), .bus(bus.cpu), .req_wr(req_wr), .req_rd(req_rd),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_from_flash(req_from_flash),
        .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .code_unprotected(code_unprotected));
    fci_checker_sva u_fci_checker_sva (
        .clock(clock), .rst_n(rst_n), .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
        .wdata(bus.wdata), .fetch_from_flash(bus.fetch_from_flash), .rdata(bus.rdata),
        .busy(bus.busy), .code_unprotected(bus.code_unprotected));
    always #12.5 clock = ~clock;
    task automatic finish_test();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (prog_req === 1'b1) begin
            nprog++;
            got_a = prog_addr;
            got_d = prog_data;
        end
        if (erase_block_req === 1'b1) nblk++;
        if (chip_erase_req === 1'b1) nchip++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_cmd(input logic [19:0] a, input logic [15:0] d, input logic fl);
        @(posedge clock);
        req_wr <= 1'b1;
        req_addr <= a;
        req_wdata <= d;
        req_from_flash <= fl;
        @(posedge clock);
        req_wr <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    // Coded cycles come from RAM; upper address and data bits are random don't-cares.
    task automatic cw(input logic [13:0] a, input logic [7:0] c);
        wr_cmd({6'($urandom), a}, {8'($urandom), c}, 1'b0);
    endtask
    task automatic unl();
        cw(14'h1554, 8'hA8);
        cw(14'h2AA8, 8'h54);
    endtask
    task automatic erase6(input logic [19:0] a6, input logic [7:0] c6);
        unl();
        cw(14'h1554, 8'h80);
        unl();
        wr_cmd(a6, {8'($urandom), c6}, 1'b0);
    endtask
    task automatic rd_cmd(output logic [15:0] d);
        @(posedge clock);
        req_rd <= 1'b1;
        req_addr <= 20'($urandom);
        @(posedge clock);
        req_rd <= 1'b0;
        for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge clock);
        d = rd_data;
        chk(n < 20, 1);
    endtask
    task automatic wait_idle();
        for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clock);
        chk(busy, 0);
    endtask
    initial begin
        void'($urandom(32'hC180F8E5));
        array_rdata <= 16'($urandom);
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd_cmd(rv);
        chk(rv, array_rdata);
        // Only flash-fetched writes of the two codes may move protection.
        for (int i = 0; i < 4; i++) begin
            wr_cmd(20'($urandom), i[1] ? 16'hFFFB : 16'hFFFF, i[0]);
            chk(code_unprotected, i == 1 || i == 2);
        end
        wa = 20'($urandom);
        wa_d = 16'($urandom);
        unl();
        cw(14'h1554, 8'hA0);
        wr_cmd(wa, wa_d, 1'b0);
        rd_cmd(rv);
        chk(rv[7], 0);
        rd_cmd(rv2);
        chk(rv[6] ^ rv2[6], 1);
        chk(nprog, 1);
        chk(got_a, wa);
        chk(got_d, wa_d);
        wait_idle();
        for (int k = 0; k < 3; k++) begin
            cw(14'h1554, k == 0 ? 8'h12 : 8'hA8);
            cw(14'h2AA8, k == 1 ? 8'h12 : 8'h54);
            cw(14'h1554, k == 2 ? 8'h12 : 8'hA0);
            wr_cmd(wa, wa_d, 1'b0);
            @(negedge clock);
            chk(nprog, 1);
        end
        array_rdata <= 16'($urandom);
        unl();
        cw(14'h1554, 8'hF0);
        rd_cmd(rv);
        chk(rv, array_rdata);
        erase6(20'($urandom), 8'h30);
        repeat (15) @(posedge clock);
        // The second confirm lands one cycle before the window would close.
        ba = 20'($urandom);
        wr_cmd(ba, 16'h0030, 1'b0);
        rd_cmd(rv);
        chk(rv[3], 0);
        chk(nblk, 2);
        chk(erase_block_addr, ba);
        repeat (20) @(posedge clock);
        rd_cmd(rv);
        chk(rv[3], 1);
        chk(rv[7], 0);
        cw(14'($urandom), 8'hB0);
        chk(erase_suspended, 1);
        cw(14'($urandom), 8'h30);
        chk(erase_suspended, 0);
        wait_idle();
        rd_cmd(rv);
        chk(rv, array_rdata);
        erase6({6'($urandom), 14'h1554}, 8'h10);
        for (n = 0; n < 100 && nchip == 0; n++) @(negedge clock);
        chk(nchip, 1);
        wait_idle();
        finish_test();
    end
endmodule
`default_nettype wire
